/* verilog/arc_ctrl.sv */
// Converter control top: registers, result placement and done interrupt.
// Assumes a register port with single-cycle strobes and read data one
// cycle after the read strobe; the analog comparator is synchronous.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module arc_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_cmp,
  output logic [9:0] o_trial,
  output logic [4:0] o_channel_select,
  output logic o_channel_valid,
  output logic o_converter_enable,
  output logic o_sampling,
  output logic o_negative_ref_select,
  output logic [1:0] o_positive_ref_select,
  output logic o_irq
);

  // Address match for a given register offset
  function automatic logic hit(input logic [2:0] a,
                               input logic [2:0] off);
    hit = (a == off);
  endfunction

  // A channel code is wired to an input outside the reserved span
  function automatic logic chan_connected(input logic [4:0] c);
    chan_connected = (c < arc_pkg::CHS_RSV_LO) ||
                     (c > arc_pkg::CHS_RSV_HI);
  endfunction

  arc_sar_if sar_bus ();

  // Control register zero fields
  logic converter_enable_q;
  logic go_q;
  logic [4:0] channel_select_q;
  logic channel_valid_q;

  // Control register one fields
  logic format_select_q;
  logic [2:0] conversion_clock_select_q;
  logic negative_ref_select_q;
  logic [1:0] positive_ref_select_q;

  // Result registers, no reset on purpose
  logic [7:0] result_high_reg_q;
  logic [7:0] result_low_reg_q;

  // Interrupt state
  logic conversion_done_flag_q;
  logic conversion_done_flag_d;
  logic irq_mask_q;
  logic irq_q;

  // Read path
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Decoded strobes
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_res_hi;
  logic wr_res_lo;
  logic wr_mask;
  logic rd_stat;
  logic new_enable;
  logic new_go;

  assign wr_ctrl0 = i_wr && hit(i_addr, arc_pkg::OFF_CTRL0);
  assign wr_ctrl1 = i_wr && hit(i_addr, arc_pkg::OFF_CTRL1);
  assign wr_res_hi = i_wr && hit(i_addr, arc_pkg::OFF_RES_HI);
  assign wr_res_lo = i_wr && hit(i_addr, arc_pkg::OFF_RES_LO);
  assign wr_mask = i_wr && hit(i_addr, arc_pkg::OFF_IRQ_MASK);
  assign rd_stat = i_rd && hit(i_addr, arc_pkg::OFF_IRQ_STAT);

  assign new_enable = i_wdata[arc_pkg::C0_ENABLE_BIT];
  assign new_go = i_wdata[arc_pkg::C0_GO_BIT];

  // Start only from idle with the converter enabled
  assign sar_bus.start = wr_ctrl0 && new_go && new_enable &&
                         !go_q && !sar_bus.busy;

  // Clearing the status bit or the enable stops a conversion early
  assign sar_bus.abort = wr_ctrl0 && go_q && (!new_go || !new_enable);

  assign sar_bus.tad_sel = conversion_clock_select_q;
  assign sar_bus.cmp = i_cmp;

  // Enable and channel fields of control register zero
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      converter_enable_q <= arc_pkg::CTRL_RST[arc_pkg::C0_ENABLE_BIT];
      channel_select_q <= arc_pkg::CTRL_RST[6:2];
      channel_valid_q <= 1'b1;
    end
    else if (wr_ctrl0)
    begin
      converter_enable_q <= new_enable;
      channel_select_q <= i_wdata[arc_pkg::C0_CHS_LSB +: 5];
      channel_valid_q <=
        chan_connected(i_wdata[arc_pkg::C0_CHS_LSB +: 5]);
    end

  // Conversion status: set by software, cleared by hardware at the end
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      go_q <= arc_pkg::CTRL_RST[arc_pkg::C0_GO_BIT];
    else if (wr_ctrl0)
      // A go write landing on the done edge must not leave go stuck high
      go_q <= new_go && new_enable && !sar_bus.done;
    else if (sar_bus.done)
      go_q <= 1'b0;

  // Control register one fields
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      format_select_q <= arc_pkg::CTRL_RST[arc_pkg::C1_FMT_BIT];
      conversion_clock_select_q <= arc_pkg::CTRL_RST[6:4];
      negative_ref_select_q <= arc_pkg::CTRL_RST[arc_pkg::C1_NREF_BIT];
      positive_ref_select_q <= arc_pkg::CTRL_RST[1:0];
    end
    else if (wr_ctrl1)
    begin
      format_select_q <= i_wdata[arc_pkg::C1_FMT_BIT];
      conversion_clock_select_q <= i_wdata[arc_pkg::C1_CLK_LSB +: 3];
      negative_ref_select_q <= i_wdata[arc_pkg::C1_NREF_BIT];
      positive_ref_select_q <= i_wdata[arc_pkg::C1_PREF_LSB +: 2];
    end

  // High result register: conversion end wins over a software write
  always_ff @(posedge i_clk)
    if (sar_bus.done)
    begin
      if (format_select_q)
        result_high_reg_q <= {6'h00, sar_bus.result[9:8]};
      else
        result_high_reg_q <= sar_bus.result[9:2];
    end
    else if (wr_res_hi)
      result_high_reg_q <= i_wdata;

  // Low result register, loaded in the same cycle as the high one
  always_ff @(posedge i_clk)
    if (sar_bus.done)
    begin
      if (format_select_q)
        result_low_reg_q <= sar_bus.result[7:0];
      else
        result_low_reg_q <= {sar_bus.result[1:0], 6'h00};
    end
    else if (wr_res_lo)
      result_low_reg_q <= i_wdata;

  // Done flag: a new completion beats the read that clears it
  always_comb
  begin
    conversion_done_flag_d = conversion_done_flag_q;
    if (rd_stat)
      conversion_done_flag_d = 1'b0;
    if (sar_bus.done)
      conversion_done_flag_d = 1'b1;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      conversion_done_flag_q <= 1'b0;
    else
      conversion_done_flag_q <= conversion_done_flag_d;

  // Interrupt mask
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      irq_mask_q <= 1'b0;
    else if (wr_mask)
      irq_mask_q <= i_wdata[arc_pkg::IRQ_DONE_BIT];

  // Level interrupt from the next flag and mask values
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      irq_q <= 1'b0;
    else
      irq_q <= conversion_done_flag_d &&
               (wr_mask ? i_wdata[arc_pkg::IRQ_DONE_BIT] : irq_mask_q);

  // Read multiplexer; unmapped offsets and unused bits read zero
  always_comb
  begin
    rdata_d = 8'h00;
    unique case (i_addr)
      arc_pkg::OFF_CTRL0:
      begin
        rdata_d[arc_pkg::C0_ENABLE_BIT] = converter_enable_q;
        rdata_d[arc_pkg::C0_GO_BIT] = go_q;
        rdata_d[arc_pkg::C0_CHS_LSB +: 5] = channel_select_q;
      end
      arc_pkg::OFF_CTRL1:
      begin
        rdata_d[arc_pkg::C1_FMT_BIT] = format_select_q;
        rdata_d[arc_pkg::C1_CLK_LSB +: 3] = conversion_clock_select_q;
        rdata_d[arc_pkg::C1_NREF_BIT] = negative_ref_select_q;
        rdata_d[arc_pkg::C1_PREF_LSB +: 2] = positive_ref_select_q;
      end
      arc_pkg::OFF_RES_HI:
        rdata_d = result_high_reg_q;
      arc_pkg::OFF_RES_LO:
        rdata_d = result_low_reg_q;
      arc_pkg::OFF_IRQ_STAT:
        rdata_d[arc_pkg::IRQ_DONE_BIT] = conversion_done_flag_q;
      arc_pkg::OFF_IRQ_MASK:
        rdata_d[arc_pkg::IRQ_DONE_BIT] = irq_mask_q;
      default:
        rdata_d = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      rdata_q <= 8'h00;
    else if (i_rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= 8'h00;

  arc_sar u_sar (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .s(sar_bus.sar)
  );

  // Outputs, each from a register
  assign o_rdata = rdata_q;
  assign o_trial = sar_bus.trial;
  assign o_channel_select = channel_select_q;
  assign o_channel_valid = channel_valid_q;
  assign o_converter_enable = converter_enable_q;
  assign o_sampling = go_q;
  assign o_negative_ref_select = negative_ref_select_q;
  assign o_positive_ref_select = positive_ref_select_q;
  assign o_irq = irq_q;
endmodule

/* verilog/arc_pkg.sv */
// Constants for the converter result and control block.
// Assumes one 20 MHz clock and an 8-bit register port with 3 address bits.
// What this block does
// - With format select 0 the high result register takes result bits 9..2.
// - With format select 0 the low register takes bits 1..0 in 7..6.
// - With format select 1 the high register takes bits 9..8 in 1..0.
// - With format select 1 the low register takes result bits 7..0.
// - Both result registers are read/write and survive every reset.
// - Software sets the status bit to start; hardware clears it when done.
// - A 5-bit channel field picks the input; 01100..11100 connect nothing.
package arc_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;
  localparam int CHS_W = 5;
  localparam int TADSEL_W = 3;
  localparam int DIV_W = 7;

  // Register offsets
  localparam logic [2:0] OFF_CTRL0 = 3'h0;
  localparam logic [2:0] OFF_CTRL1 = 3'h1;
  localparam logic [2:0] OFF_RES_HI = 3'h2;
  localparam logic [2:0] OFF_RES_LO = 3'h3;
  localparam logic [2:0] OFF_IRQ_STAT = 3'h4;
  localparam logic [2:0] OFF_IRQ_MASK = 3'h5;

  // Field positions
  localparam int C0_ENABLE_BIT = 0;
  localparam int C0_GO_BIT = 1;
  localparam int C0_CHS_LSB = 2;
  localparam int C1_PREF_LSB = 0;
  localparam int C1_NREF_BIT = 2;
  localparam int C1_CLK_LSB = 4;
  localparam int C1_FMT_BIT = 7;
  localparam int IRQ_DONE_BIT = 0;

  // Reset values and channel decode limits
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] CHS_RSV_LO = 5'h0C;
  localparam logic [4:0] CHS_RSV_HI = 5'h1C;
  localparam logic [9:0] SAR_FIRST_TRIAL = 10'h200;
  localparam logic [3:0] SAR_TOP_BIT = 4'h9;

  // System clocks per conversion step for each clock select code
  localparam logic [6:0] TAD_DIV_FRC = 7'h28;
  function automatic logic [6:0] tad_div(input logic [2:0] sel);
    unique case (sel)
      3'h0: tad_div = 7'h02;
      3'h1: tad_div = 7'h08;
      3'h2: tad_div = 7'h20;
      3'h4: tad_div = 7'h04;
      3'h5: tad_div = 7'h10;
      3'h6: tad_div = 7'h40;
      default: tad_div = TAD_DIV_FRC;
    endcase
  endfunction

  typedef enum logic [1:0] {
    ARC_IDLE = 2'b00,
    ARC_SAMPLE = 2'b01,
    ARC_CONVERT = 2'b10
  } arc_state_t;
endpackage

/* verilog/arc_sar_if.sv */
// Carrier between the register front and the approximation sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface arc_sar_if;
  logic start;
  logic abort;
  logic [2:0] tad_sel;
  logic cmp;
  logic busy;
  logic done;
  logic [9:0] result;
  logic [9:0] trial;
  modport ctl (output start, abort, tad_sel, cmp,
               input busy, done, result, trial);
  modport sar (input start, abort, tad_sel, cmp,
               output busy, done, result, trial);
endinterface

/* verilog/arc_sar.sv */
// Successive approximation sequencer: one sample step, then ten bit steps.
// Assumes the comparator input says analog input is at or above the trial.
`timescale 1ns/1ps
module arc_sar (
  input wire logic i_clk,
  input wire logic i_rst_b,
  arc_sar_if.sar s
);
  arc_pkg::arc_state_t state_q;
  logic [6:0] div_q;
  logic tad;
  logic [3:0] idx_q;

  // Step enable from the selected clock divider
  assign tad = (div_q == arc_pkg::tad_div(s.tad_sel) - 7'h01);

  // Divider restarts with every conversion
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      div_q <= 7'h00;
    else if (s.start || tad || state_q == arc_pkg::ARC_IDLE)
      div_q <= 7'h00;
    else
      div_q <= div_q + 7'h01;

  // Sequencer: sample, then decide one bit per step from the top
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      state_q <= arc_pkg::ARC_IDLE;
      idx_q <= 4'h0;
      s.trial <= 10'h000;
      s.result <= 10'h000;
      s.done <= 1'b0;
    end
    else
    begin
      s.done <= 1'b0;
      if (s.abort)
        state_q <= arc_pkg::ARC_IDLE;
      else
        unique case (state_q)
          arc_pkg::ARC_IDLE:
            if (s.start)
              state_q <= arc_pkg::ARC_SAMPLE;
          arc_pkg::ARC_SAMPLE:
            if (tad)
            begin
              state_q <= arc_pkg::ARC_CONVERT;
              s.trial <= arc_pkg::SAR_FIRST_TRIAL;
              idx_q <= arc_pkg::SAR_TOP_BIT;
            end
          arc_pkg::ARC_CONVERT:
            if (tad)
            begin
              if (idx_q == 4'h0)
              begin
                s.result <= {s.trial[9:1], s.cmp};
                s.done <= 1'b1;
                state_q <= arc_pkg::ARC_IDLE;
              end
              else
              begin
                s.trial[idx_q] <= s.cmp;
                s.trial[idx_q - 4'h1] <= 1'b1;
                idx_q <= idx_q - 4'h1;
              end
            end
          default:
            state_q <= arc_pkg::ARC_IDLE;
        endcase
    end

  assign s.busy = (state_q != arc_pkg::ARC_IDLE);
endmodule

/* tb/arc_ctrl_asserts.sv */
// Checker for the converter control top, bound to its ports.
// Assumes one clock and the register offsets of the package.
`timescale 1ns/1ps
module arc_ctrl_asserts (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [4:0] o_channel_select,
  input wire logic o_channel_valid,
  input wire logic o_converter_enable,
  input wire logic o_sampling,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic [7:0] wd_q;
  logic w0;
  // Control word writes
  assign w0 = i_wr && i_addr == arc_pkg::OFF_CTRL0;
  // Write data one cycle back
  always_ff @(posedge i_clk)
  begin
    wd_q <= i_wdata;
  end
  property p_rd_quiet; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data outside read slot");
  property p_go; w0 && i_wdata[1:0] == 2'h3 && !o_sampling |=> o_sampling;
  endproperty
  a_go: assert property (p_go)
    else $error("start not taken");
  property p_go_off; w0 && !i_wdata[0] |=> !o_sampling; endproperty
  a_go_off: assert property (p_go_off)
    else $error("busy while disabled");
  property p_ends; $rose(o_sampling) |-> ##[1:1000] !o_sampling; endproperty
  a_ends: assert property (p_ends)
    else $error("conversion never ends");
  property p_irq; $rose(o_irq) |-> $fell(o_sampling) || $past(i_wr);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without completion");
  property p_abort; w0 && !i_wdata[1] |=> !o_sampling; endproperty
  a_abort: assert property (p_abort)
    else $error("status bit kept after clear");
  property p_chs; w0 |=> o_channel_select == wd_q[6:2]; endproperty
  a_chs: assert property (p_chs)
    else $error("channel field not loaded");
  property p_chv;
    o_channel_valid == !(o_channel_select inside {[5'h0C:5'h1C]});
  endproperty
  a_chv: assert property (p_chv)
    else $error("channel valid wrong");
  property p_en; w0 |=> o_converter_enable == wd_q[0]; endproperty
  a_en: assert property (p_en)
    else $error("enable not loaded");
  // Main scenarios reached
  c_done: cover property ($fell(o_sampling));
  c_irq: cover property ($rose(o_irq));
  c_abort: cover property (o_sampling && w0 && i_wdata[1:0] != 2'h3);
endmodule

bind arc_ctrl arc_ctrl_asserts u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_channel_select(o_channel_select),
  .o_channel_valid(o_channel_valid), .o_converter_enable(o_converter_enable),
  .o_sampling(o_sampling), .o_irq(o_irq));

/* tb/arc_ctrl_tb.sv */
// Self-checking bench for the converter control top.
// Assumes a comparator that follows the trial word one clock later.
`timescale 1ns/1ps
module arc_ctrl_tb;
  typedef struct {logic f; logic [9:0] v; logic [7:0] hi; logic [7:0] lo;}
    arc_row_t;
  localparam int ACQ = 4; // Acquisition wait in clocks, assumed
  logic i_clk, i_rst_b, i_wr, i_rd, i_cmp;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, rd_v;
  logic [9:0] o_trial, vin;
  logic [4:0] o_channel_select;
  logic o_channel_valid, o_converter_enable, o_sampling, o_irq, o_nref;
  logic [1:0] o_pref;
  int miscompares = 0;
  int cmp_count = 0;
  logic [4:0] chans [5] = '{5'h0B, 5'h0C, 5'h15, 5'h1C, 5'h1D};
  arc_row_t rows [5] = '{
    '{1'b0, 10'h3FF, 8'hFF, 8'hC0}, '{1'b0, 10'h2A5, 8'hA9, 8'h40},
    '{1'b0, 10'h001, 8'h00, 8'h40}, '{1'b1, 10'h2A5, 8'h02, 8'hA5},
    '{1'b1, 10'h100, 8'h01, 8'h00}};

  arc_ctrl uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cmp(i_cmp), .o_trial(o_trial), .o_channel_select(o_channel_select),
    .o_channel_valid(o_channel_valid), .o_converter_enable(o_converter_enable),
    .o_sampling(o_sampling), .o_negative_ref_select(o_nref),
    .o_positive_ref_select(o_pref), .o_irq(o_irq));

  // Clock
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Comparator: input at or above the trial
  always @(posedge i_clk) i_cmp <= (vin >= o_trial);

  task automatic chk(string n, logic [9:0] s, logic [9:0] e);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(logic [2:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    rd_v = o_rdata;
  endtask

  // One conversion at the fastest step rate
  task automatic conv(logic f, logic [9:0] v);
    int i;
    vin = v;
    wr(3'h1, {f, 7'h00});
    wr(3'h0, 8'h01);
    repeat (ACQ) @(posedge i_clk);
    wr(3'h0, 8'h03);
    @(negedge i_clk);
    chk("busy", o_sampling, 1'b1);
    i = 1;
    while (o_sampling === 1'b1 && i < 2000)
    begin
      @(negedge i_clk);
      i++;
    end
    // Start edge, one sample step and ten bit steps of two clocks, end edge
    chk("length", 10'(i), 10'h018);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #(20000 * 50);
    miscompares++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    i_rst_b = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_cmp = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    vin = 10'h000;
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(3'h0);
    chk("ctrl0", rd_v, 8'h00);
    chk("chvalid", o_channel_valid, 1'b1);
    foreach (rows[k])
    begin
      conv(rows[k].f, rows[k].v);
      rd(3'h2);
      chk("res_hi", rd_v, rows[k].hi);
      rd(3'h3);
      chk("res_lo", rd_v, rows[k].lo);
    end
    // Results written by software survive a reset
    wr(3'h2, 8'h5A);
    wr(3'h3, 8'hC3);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(3'h2);
    chk("keep_hi", rd_v, 8'h5A);
    rd(3'h3);
    chk("keep_lo", rd_v, 8'hC3);
    // Channel codes on both sides of the reserved span
    foreach (chans[k])
    begin
      wr(3'h0, {1'b0, chans[k], 2'b00});
      @(negedge i_clk);
      chk("chvalid", o_channel_valid,
        chans[k] < 5'h0C || chans[k] > 5'h1C);
    end
    // Start while disabled, then abort during the sample step
    wr(3'h0, 8'h02);
    @(negedge i_clk);
    chk("go_off", o_sampling, 1'b0);
    wr(3'h0, 8'h03);
    wr(3'h0, 8'h01);
    @(negedge i_clk);
    chk("abort", o_sampling, 1'b0);
    chk("enable", o_converter_enable, 1'b1);
    // Done interrupt raised, cleared by read, then masked
    rd(3'h4);
    wr(3'h5, 8'h01);
    conv(1'b1, 10'h155);
    chk("irq", o_irq, 1'b1);
    rd(3'h4);
    chk("stat", rd_v, 8'h01);
    chk("irq_clr", o_irq, 1'b0);
    wr(3'h5, 8'h00);
    conv(1'b0, 10'h155);
    chk("irq_mask", o_irq, 1'b0);
    rd(3'h4);
    chk("stat", rd_v, 8'h01);
    rd(3'h6);
    chk("unmapped", rd_v, 8'h00);
    // Reference selects and format bit of control word one
    wr(3'h1, 8'h85);
    @(negedge i_clk);
    chk("nref", o_nref, 1'b1);
    chk("pref", o_pref, 2'h1);
    rd(3'h1);
    chk("ctrl1", rd_v, 8'h85);
    tally_and_finish();
  end
endmodule
